/* css_pkg.sv */
// Constants and state encoding for the clock start-up supervisor.
package css_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CSS_CLK_MHZ = 100;
  // Quality check time-out, shortest documented figure, in ms.
  localparam int unsigned CSS_QC_TIMEOUT_MS = 450;
  localparam int unsigned CSS_QC_TIMEOUT_CYC =
    CSS_QC_TIMEOUT_MS * CSS_CLK_MHZ * 1000;
  // Clock monitor fail threshold, lowest documented figure, in kHz.
  localparam int unsigned CSS_MON_FAIL_KHZ = 50;
  // Longest oscillator period accepted, rounded down to whole cycles.
  localparam int unsigned CSS_MON_FAIL_CYC =
    (CSS_CLK_MHZ * 1000) / CSS_MON_FAIL_KHZ;
  // Least reset pulse, in oscillator periods.
  localparam int unsigned CSS_RESET_PULSE_MIN = 2;
  // Longest wait recovery, in bus cycles.
  localparam int unsigned CSS_WAKE_MAX_CYC = 14;
  // Oscillator edges that make an oscillation valid.
  localparam int unsigned CSS_QC_OSC_EDGES = 4096;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic CSS_POWER_ON_FLAG_RST = 1'b1;
  localparam logic CSS_OSC_TYPE_RST = 1'b1;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    CSS_ST_RESET = 3'b000,
    CSS_ST_CHECK = 3'b001,
    CSS_ST_RUN_OSC = 3'b010,
    CSS_ST_RUN_SELF = 3'b011,
    CSS_ST_STOP = 3'b100,
    CSS_ST_IDLE = 3'b101,
    CSS_ST_WAKE = 3'b110
  } css_state_e;

endpackage

/* css_clock_startup_supervisor.sv */
// Clock start-up, recovery and monitor sequencer of the clock generator.
`timescale 1ns/1ps

// Function
// - Power-on reset release starts oscillator and quality check first.
// - Low-voltage reset release starts oscillator and quality check too.
// - No valid oscillation before time-out selects the internal self clock.
// - Reset pin held two oscillator periods produces an internal reset.
// - External reset with running oscillator fetches reset vector, no check.
// - STOP ends only on external interrupt or reset, then full quality check.
// - Pseudo STOP or wait wakes on any interrupt without a check.
// - Interrupt vector fetch starts within 14 bus cycles after such wake.
// - Oscillator-select strap sampled during reset picks the oscillator type.
// - Every oscillator start, including after failure, runs the check.
// - Clock monitor flags failure when oscillator frequency drops too low.
// - Power-on reset sets the power-on flag; clear means SRAM retained.
module css_clock_startup_supervisor
  import css_pkg::*;
#(
  parameter int unsigned QC_TIMEOUT_CYCLES = CSS_QC_TIMEOUT_CYC,
  parameter int unsigned QC_OSC_EDGES = CSS_QC_OSC_EDGES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // Supply monitors and reset pin, asynchronous
  input wire logic i_power_on_reset,
  input wire logic i_low_voltage_reset,
  input wire logic i_ext_resetn,
  // Oscillator side, asynchronous
  input wire logic i_osc_clk,
  input wire logic i_osc_type_strap,
  // Interrupts and low-power requests
  input wire logic i_ext_irq,
  input wire logic i_int_irq,
  input wire logic i_stop_req,
  input wire logic i_pstop_req,
  input wire logic i_wait_req,
  // Flag control
  input wire logic i_power_on_flag_clr,
  // Clock control outputs
  output logic o_osc_enable,
  output logic o_sys_clk_osc,
  output logic o_self_clock,
  output logic o_clocks_released,
  output logic o_osc_colpitts,
  // Reset and vector outputs
  output logic o_internal_reset,
  output logic o_fetch_reset_vector,
  output logic o_fetch_irq_vector,
  // Status outputs
  output logic o_power_on_flag,
  output logic o_monitor_fail,
  output logic o_check_active
);

  // The check counters below are 26 and 16 bits wide.
  if (QC_TIMEOUT_CYCLES < 1 ||
      QC_TIMEOUT_CYCLES > 32'h03FFFFFF) begin : g_bad_timeout
    $error("QC_TIMEOUT_CYCLES out of range");
  end
  if (QC_OSC_EDGES < 2 || QC_OSC_EDGES > 32'h0000FFFF) begin : g_bad_edges
    $error("QC_OSC_EDGES out of range");
  end

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Oscillators above half the sampling rate alias; the monitor then
  // sees fewer edges, which can only make a check pass later.
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic osc_prev_q;
  wire [6:0] async_in = {i_osc_clk, i_power_on_reset, i_low_voltage_reset,
                         ~i_ext_resetn, i_osc_type_strap, i_ext_irq,
                         i_int_irq};

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
      osc_prev_q <= 1'b0;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
      osc_prev_q <= sync2_q[6];
    end
  end

  wire osc_s = sync2_q[6];
  wire por_s = sync2_q[5];
  wire lvr_s = sync2_q[4];
  wire pin_rst_s = sync2_q[3];
  wire strap_s = sync2_q[2];
  wire ext_irq_s = sync2_q[1];
  wire int_irq_s = sync2_q[0];
  wire osc_edge = osc_s & ~osc_prev_q;
  wire supply_rst = por_s | lvr_s;

  // ****************************************************************
  // Counters and state
  // ****************************************************************
  css_state_e state_q;
  css_state_e state_d;
  logic [25:0] tmo_q;
  logic [15:0] edges_q;
  logic [11:0] mon_q;
  logic [1:0] pin_cnt_q;
  logic [3:0] wake_q;
  logic osc_ran_q;
  logic from_reset_q;
  logic after_fail_q;
  logic self_mode_q;

  localparam logic [25:0] TMO_END = 26'(QC_TIMEOUT_CYCLES - 1);
  localparam logic [15:0] EDGES_END = 16'(QC_OSC_EDGES);
  localparam logic [11:0] MON_END = 12'(CSS_MON_FAIL_CYC);
  localparam logic [1:0] PIN_END = 2'(CSS_RESET_PULSE_MIN);
  localparam logic [3:0] WAKE_END = 4'(CSS_WAKE_MAX_CYC - 1);

  wire in_check = (state_q == CSS_ST_CHECK);
  wire osc_valid = in_check && (edges_q == EDGES_END);
  wire check_tmo = in_check && !osc_valid && (tmo_q == TMO_END);
  wire osc_running = (state_q == CSS_ST_RUN_OSC) ||
                     (state_q == CSS_ST_IDLE && !self_mode_q) ||
                     (state_q == CSS_ST_WAKE && !self_mode_q);
  wire mon_fail = osc_running && (mon_q == MON_END);
  // Pulse width counts oscillator edges; on self clock, bus cycles.
  wire pin_tick = osc_running ? osc_edge : 1'b1;
  wire pin_rst_hit = pin_rst_s && (pin_cnt_q == PIN_END);
  wire any_irq = ext_irq_s | int_irq_s;
  wire wake_done = (state_q == CSS_ST_WAKE) && (wake_q == WAKE_END);
  wire run_state = (state_q == CSS_ST_RUN_OSC) ||
                   (state_q == CSS_ST_RUN_SELF);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CSS_ST_RESET: begin
        if (!supply_rst && !pin_rst_s) begin
          if (osc_ran_q) begin
            state_d = CSS_ST_RUN_OSC;
          end else begin
            state_d = CSS_ST_CHECK;
          end
        end
      end
      CSS_ST_CHECK: begin
        if (osc_valid) begin
          state_d = CSS_ST_RUN_OSC;
        end else if (check_tmo) begin
          state_d = CSS_ST_RUN_SELF;
        end
      end
      CSS_ST_RUN_OSC, CSS_ST_RUN_SELF: begin
        if (mon_fail) begin
          state_d = CSS_ST_CHECK;
        end else if (i_stop_req) begin
          state_d = CSS_ST_STOP;
        end else if (i_pstop_req || i_wait_req) begin
          state_d = CSS_ST_IDLE;
        end
      end
      CSS_ST_STOP: begin
        if (ext_irq_s) begin
          state_d = CSS_ST_CHECK;
        end
      end
      CSS_ST_IDLE: begin
        if (mon_fail) begin
          state_d = CSS_ST_CHECK;
        end else if (any_irq) begin
          state_d = CSS_ST_WAKE;
        end
      end
      CSS_ST_WAKE: begin
        if (wake_done) begin
          state_d = self_mode_q ? CSS_ST_RUN_SELF : CSS_ST_RUN_OSC;
        end
      end
      default: begin
        state_d = CSS_ST_RESET;
      end
    endcase
    if (supply_rst || pin_rst_hit) begin
      state_d = CSS_ST_RESET;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= CSS_ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Check, monitor, pin and wake counters
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      tmo_q <= 26'h0000000;
      edges_q <= 16'h0000;
    end else if (!in_check || state_d != CSS_ST_CHECK) begin
      tmo_q <= 26'h0000000;
      edges_q <= 16'h0000;
    end else begin
      tmo_q <= tmo_q + 26'h0000001;
      if (osc_edge) begin
        edges_q <= edges_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      mon_q <= 12'h000;
    end else if (osc_edge || !osc_running) begin
      mon_q <= 12'h000;
    end else if (mon_q != MON_END) begin
      mon_q <= mon_q + 12'h001;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_cnt_q <= 2'h0;
    end else if (!pin_rst_s) begin
      pin_cnt_q <= 2'h0;
    end else if (pin_tick && pin_cnt_q != PIN_END) begin
      pin_cnt_q <= pin_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wake_q <= 4'h0;
    end else if (state_q != CSS_ST_WAKE) begin
      wake_q <= 4'h0;
    end else begin
      wake_q <= wake_q + 4'h1;
    end
  end

  // ****************************************************************
  // History flags
  // ****************************************************************
  // A supply reset forgets the oscillator; a pin reset keeps it.
  wire osc_ran_d = supply_rst ? 1'b0 :
                   (state_q == CSS_ST_RESET) ? osc_ran_q :
                   osc_running;
  wire from_reset_d = (state_q == CSS_ST_RESET) ? 1'b1 :
                      run_state ? 1'b0 : from_reset_q;
  wire after_fail_d = mon_fail ? 1'b1 :
                      (state_q == CSS_ST_STOP ||
                       state_q == CSS_ST_RESET) ? 1'b0 : after_fail_q;
  wire self_mode_d = (state_q == CSS_ST_RUN_SELF) ? 1'b1 :
                     (state_q == CSS_ST_RUN_OSC) ? 1'b0 : self_mode_q;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      osc_ran_q <= 1'b0;
      from_reset_q <= 1'b1;
      after_fail_q <= 1'b0;
      self_mode_q <= 1'b0;
    end else begin
      osc_ran_q <= osc_ran_d;
      from_reset_q <= from_reset_d;
      after_fail_q <= after_fail_d;
      self_mode_q <= self_mode_d;
    end
  end

  // ****************************************************************
  // Output decode
  // ****************************************************************
  wire st_run_d = (state_d == CSS_ST_RUN_OSC) ||
                  (state_d == CSS_ST_RUN_SELF);
  wire osc_enable_d = (state_d != CSS_ST_STOP) &&
                      (state_d != CSS_ST_RUN_SELF) &&
                      !(state_d == CSS_ST_IDLE && self_mode_d) &&
                      !(state_d == CSS_ST_WAKE && self_mode_d);
  wire sys_osc_d = (state_d == CSS_ST_RUN_OSC) ||
                   ((state_d == CSS_ST_IDLE || state_d == CSS_ST_WAKE) &&
                    !self_mode_d);
  // After a monitor failure the system keeps running on the self clock
  // while the restarted oscillator is checked.
  wire released_d = st_run_d ||
                    (state_d == CSS_ST_CHECK && after_fail_d);
  wire fetch_rst_d = st_run_d && !run_state && from_reset_q;
  wire fetch_irq_d = (wake_done ||
                      (in_check && st_run_d && !from_reset_q &&
                       !after_fail_q));
  // The strap follows the pin only while the sequencer is in reset.
  wire osc_type_d = (state_q == CSS_ST_RESET) ? strap_s : o_osc_colpitts;
  wire pof_d = por_s | (o_power_on_flag & ~i_power_on_flag_clr);

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_osc_enable <= 1'b0;
      o_sys_clk_osc <= 1'b0;
      o_self_clock <= 1'b1;
      o_clocks_released <= 1'b0;
      o_osc_colpitts <= CSS_OSC_TYPE_RST;
      o_internal_reset <= 1'b1;
      o_fetch_reset_vector <= 1'b0;
      o_fetch_irq_vector <= 1'b0;
      o_power_on_flag <= CSS_POWER_ON_FLAG_RST;
      o_monitor_fail <= 1'b0;
      o_check_active <= 1'b0;
    end else begin
      o_osc_enable <= osc_enable_d;
      o_sys_clk_osc <= sys_osc_d;
      o_self_clock <= ~sys_osc_d;
      o_clocks_released <= released_d;
      o_osc_colpitts <= osc_type_d;
      o_internal_reset <= (state_d == CSS_ST_RESET);
      o_fetch_reset_vector <= fetch_rst_d;
      o_fetch_irq_vector <= fetch_irq_d;
      o_power_on_flag <= pof_d;
      o_monitor_fail <= mon_fail | (o_monitor_fail & ~run_state &
                                    ~(state_q == CSS_ST_RESET));
      o_check_active <= (state_d == CSS_ST_CHECK);
    end
  end

endmodule // css_clock_startup_supervisor

/* css_osc_model.sv */
// Behavioural crystal or clock source on the far side of the supervisor.
`timescale 1ns/1ps
module css_osc_model #(
  parameter int HALF_NS = 20
) (
  // Control
  input wire logic i_enable,
  input wire logic i_healthy,
  // Oscillator line
  output logic o_osc_clk
);
  // A disabled or dead crystal gives no edges, so the line stands low.
  initial begin
    o_osc_clk = 1'b0;
    forever begin
      #(HALF_NS);
      o_osc_clk = (i_enable && i_healthy) ? !o_osc_clk : 1'b0;
    end
  end
endmodule // css_osc_model

/* css_sva.sv */
// Port-level assertion checker for the clock start-up supervisor.
`timescale 1ns/1ps
module css_sva #(
  parameter int unsigned QC_TIMEOUT_CYCLES = 200
) (
  // Clock, reset and inputs
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_power_on_reset,
  input wire logic i_ext_resetn,
  input wire logic i_ext_irq,
  input wire logic i_int_irq,
  // Outputs
  input wire logic o_osc_enable,
  input wire logic o_sys_clk_osc,
  input wire logic o_self_clock,
  input wire logic o_clocks_released,
  input wire logic o_osc_colpitts,
  input wire logic o_internal_reset,
  input wire logic o_fetch_reset_vector,
  input wire logic o_fetch_irq_vector,
  input wire logic o_power_on_flag,
  input wire logic o_check_active
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  int unsigned chk_cnt_q;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) chk_cnt_q <= 0;
    else chk_cnt_q <= o_check_active ? chk_cnt_q + 1 : 0;
  end
  // ************
  // Checks
  // ************
  sequence s_stopped;
    !o_clocks_released && !o_osc_enable && !o_internal_reset &&
      !o_check_active;
  endsequence
  sequence s_idle_irq;
    !o_clocks_released && o_osc_enable && !o_check_active &&
      !o_internal_reset && (i_ext_irq || i_int_irq);
  endsequence
  a_self_not_osc: assert property (o_self_clock == !o_sys_clk_osc)
    else $error("self clock flag disagrees with source");
  a_start_check: assert property (
    $fell(o_internal_reset) && !o_fetch_reset_vector
      |-> o_check_active && o_osc_enable)
    else $error("reset release without quality check");
  a_self_after_chk: assert property (
    $rose(o_clocks_released) && o_fetch_reset_vector && o_self_clock
      |-> $past(o_check_active))
    else $error("self clock start without a check");
  a_check_bound: assert property (chk_cnt_q <= QC_TIMEOUT_CYCLES + 2)
    else $error("quality check outlived its time-out");
  a_pin_reset: assert property (
    !i_ext_resetn [*8] |-> ##[0:8] o_internal_reset)
    else $error("long pin reset gave no internal reset");
  a_wake_latency: assert property (
    s_idle_irq |-> ##[1:17] o_fetch_irq_vector)
    else $error("late interrupt vector after wake");
  a_stop_exit: assert property (
    s_stopped ##1 (o_osc_enable && !o_internal_reset)
      |-> o_check_active && ($past(i_ext_irq, 2) || $past(i_ext_irq, 3)))
    else $error("stop left without external interrupt or check");
  a_rose_osc: assert property (
    $rose(o_sys_clk_osc) |-> $past(o_check_active) || o_fetch_reset_vector)
    else $error("oscillator selected without check");
  a_por_flag: assert property (i_power_on_reset [*3] |=> o_power_on_flag)
    else $error("power-on flag not set");
  a_strap_frozen: assert property (
    !o_internal_reset && !$past(o_internal_reset) &&
      !$past(o_internal_reset, 2) |-> $stable(o_osc_colpitts))
    else $error("oscillator type changed outside reset");
endmodule // css_sva
bind css_clock_startup_supervisor css_sva #(
  .QC_TIMEOUT_CYCLES(QC_TIMEOUT_CYCLES)
) sva_u (
  .i_mclk(i_mclk), .i_resetn(i_resetn),
  .i_power_on_reset(i_power_on_reset), .i_ext_resetn(i_ext_resetn),
  .i_ext_irq(i_ext_irq), .i_int_irq(i_int_irq),
  .o_osc_enable(o_osc_enable), .o_sys_clk_osc(o_sys_clk_osc),
  .o_self_clock(o_self_clock), .o_clocks_released(o_clocks_released),
  .o_osc_colpitts(o_osc_colpitts), .o_internal_reset(o_internal_reset),
  .o_fetch_reset_vector(o_fetch_reset_vector),
  .o_fetch_irq_vector(o_fetch_irq_vector),
  .o_power_on_flag(o_power_on_flag), .o_check_active(o_check_active)
);

/* tb_top.sv */
// Self-checking bench for the clock start-up supervisor.
`timescale 1ns/1ps
module tb_top;
  localparam int QC_TMO = 200;
  logic i_mclk, i_resetn, i_power_on_reset, i_low_voltage_reset;
  logic i_ext_resetn, i_osc_clk, i_osc_type_strap, i_ext_irq, i_int_irq;
  logic i_stop_req, i_pstop_req, i_wait_req, i_power_on_flag_clr, osc_ok;
  logic o_osc_enable, o_sys_clk_osc, o_self_clock, o_clocks_released;
  logic o_osc_colpitts, o_internal_reset, o_fetch_reset_vector;
  logic o_fetch_irq_vector, o_power_on_flag, o_monitor_fail, o_check_active;
  int n_mismatch, samples_checked, n;
  css_clock_startup_supervisor #(
    .QC_TIMEOUT_CYCLES(QC_TMO), .QC_OSC_EDGES(8)) dut_u (
    .i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_power_on_reset(i_power_on_reset),
    .i_low_voltage_reset(i_low_voltage_reset),
    .i_ext_resetn(i_ext_resetn), .i_osc_clk(i_osc_clk),
    .i_osc_type_strap(i_osc_type_strap),
    .i_ext_irq(i_ext_irq), .i_int_irq(i_int_irq),
    .i_stop_req(i_stop_req), .i_pstop_req(i_pstop_req),
    .i_wait_req(i_wait_req),
    .i_power_on_flag_clr(i_power_on_flag_clr),
    .o_osc_enable(o_osc_enable), .o_sys_clk_osc(o_sys_clk_osc),
    .o_self_clock(o_self_clock), .o_clocks_released(o_clocks_released),
    .o_osc_colpitts(o_osc_colpitts), .o_internal_reset(o_internal_reset),
    .o_fetch_reset_vector(o_fetch_reset_vector),
    .o_fetch_irq_vector(o_fetch_irq_vector),
    .o_power_on_flag(o_power_on_flag), .o_monitor_fail(o_monitor_fail),
    .o_check_active(o_check_active));
  css_osc_model osc_u (.i_enable(o_osc_enable), .i_healthy(osc_ok),
    .o_osc_clk(i_osc_clk));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = !i_mclk;
  end
  // ************
  // Scenarios
  // ************
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %b expected %b", $realtime, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge i_mclk);
  endtask
  task automatic t_power_on();
    @(posedge i_mclk) i_power_on_reset <= 1'b1;
    cyc(6);
    chk(o_internal_reset, 1'b1);
    chk(o_power_on_flag, 1'b1);
    @(posedge i_mclk) i_power_on_reset <= 1'b0;
    cyc(5);
    chk(o_check_active && o_osc_enable, 1'b1);
    for (n = 0; n < 100 && o_sys_clk_osc !== 1'b1; n++) cyc(1);
    chk(o_clocks_released && !o_check_active, 1'b1);
    @(posedge i_mclk) i_power_on_flag_clr <= 1'b1;
    @(posedge i_mclk) i_power_on_flag_clr <= 1'b0;
    cyc(2);
    chk(o_power_on_flag, 1'b0);
  endtask
  task automatic t_ext_reset();
    // The short pulse sits below two oscillator periods.
    @(posedge i_mclk) i_ext_resetn <= 1'b0;
    @(posedge i_mclk) i_ext_resetn <= 1'b1;
    cyc(6);
    chk(o_internal_reset, 1'b0);
    @(posedge i_mclk) i_ext_resetn <= 1'b0;
    cyc(14);
    chk(o_internal_reset, 1'b1);
    @(posedge i_mclk) i_ext_resetn <= 1'b1;
    for (n = 0; n < 20 && o_fetch_reset_vector !== 1'b1; n++) cyc(1);
    chk(o_fetch_reset_vector && o_sys_clk_osc, 1'b1);
    chk(o_check_active, 1'b0);
    chk(o_power_on_flag, 1'b0);
  endtask
  task automatic t_nap(input logic use_wait);
    @(posedge i_mclk) begin
      i_pstop_req <= !use_wait;
      i_wait_req <= use_wait;
    end
    @(posedge i_mclk) begin
      i_pstop_req <= 1'b0;
      i_wait_req <= 1'b0;
    end
    cyc(3);
    chk(o_clocks_released, 1'b0);
    @(posedge i_mclk) begin
      i_ext_irq <= use_wait;
      i_int_irq <= !use_wait;
    end
    // Count from the first edge that samples the interrupt.
    cyc(1);
    for (n = 0; n < 30 && o_fetch_irq_vector !== 1'b1; n++) cyc(1);
    chk(o_fetch_irq_vector && n <= 17, 1'b1);
    chk(o_osc_enable && !o_check_active, 1'b1);
    @(posedge i_mclk) begin
      i_ext_irq <= 1'b0;
      i_int_irq <= 1'b0;
    end
    cyc(2);
    chk(o_clocks_released, 1'b1);
  endtask
  task automatic t_stop();
    @(posedge i_mclk) i_stop_req <= 1'b1;
    @(posedge i_mclk) i_stop_req <= 1'b0;
    cyc(3);
    chk(o_osc_enable || o_clocks_released, 1'b0);
    @(posedge i_mclk) i_int_irq <= 1'b1;
    cyc(8);
    chk(o_check_active || o_clocks_released, 1'b0);
    @(posedge i_mclk) begin
      i_int_irq <= 1'b0;
      i_ext_irq <= 1'b1;
    end
    for (n = 0; n < 10 && o_check_active !== 1'b1; n++) cyc(1);
    chk(o_check_active && !o_clocks_released, 1'b1);
    for (n = 0; n < 100 && o_clocks_released !== 1'b1; n++) cyc(1);
    chk(o_sys_clk_osc, 1'b1);
    chk(o_fetch_irq_vector, 1'b1);
    @(posedge i_mclk) i_ext_irq <= 1'b0;
  endtask
  task automatic t_monitor();
    @(posedge i_mclk) osc_ok <= 1'b0;
    for (n = 0; n < 2100 && o_monitor_fail !== 1'b1; n++) cyc(1);
    chk(o_monitor_fail && n > 1990, 1'b1);
    chk(o_check_active, 1'b1);
    // The self clock carries the system during the recheck, so wait for
    // the check to end rather than for the clock source to change.
    for (n = 0; n < QC_TMO + 20 && o_check_active !== 1'b0; n++) cyc(1);
    chk(o_self_clock && n >= QC_TMO - 5, 1'b1);
    chk(o_clocks_released && !o_osc_enable, 1'b1);
  endtask
  task automatic t_lvr();
    @(posedge i_mclk) begin
      i_osc_type_strap <= 1'b0;
      i_low_voltage_reset <= 1'b1;
    end
    cyc(6);
    chk(o_internal_reset, 1'b1);
    @(posedge i_mclk) i_low_voltage_reset <= 1'b0;
    cyc(5);
    chk(o_check_active && o_osc_enable, 1'b1);
    @(posedge i_mclk) i_osc_type_strap <= 1'b1;
    for (n = 0; n < QC_TMO + 20 && o_fetch_reset_vector !== 1'b1; n++) cyc(1);
    chk(o_fetch_reset_vector && o_self_clock, 1'b1);
    chk(o_osc_colpitts, 1'b0);
  endtask
  task automatic results();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    {n_mismatch, samples_checked, n} = '0;
    {i_power_on_reset, i_low_voltage_reset, i_ext_irq, i_int_irq} = 4'h0;
    {i_stop_req, i_pstop_req, i_wait_req, i_power_on_flag_clr} = 4'h0;
    {i_ext_resetn, i_osc_type_strap, osc_ok} = 3'h7;
    i_resetn = 1'b0;
    repeat (3) @(posedge i_mclk);
    i_resetn <= 1'b1;
    cyc(60);
    t_power_on();
    t_ext_reset();
    t_nap(1'b0);
    t_nap(1'b1);
    t_stop();
    t_monitor();
    t_lvr();
    results();
  end
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
endmodule // tb_top
